// [hdl/iau_pkg.sv]
// Shared constants and types of the indirect address unit
package iau_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PTR_W   = 16;
    localparam int RAM_AW  = 12;
    localparam int PROG_AW = 15;
    localparam int DW      = 8;
    localparam int BANK_W  = 5;
    localparam int FA_W    = 7;
    localparam int LIT_W   = 6;

    // ****************************************************************
    // Pointer address map
    // ****************************************************************
    localparam logic [15:0] BANKED_LAST = 16'h0fff;
    localparam logic [15:0] RSV_LO_LAST = 16'h1fff;
    localparam logic [15:0] LIN_FIRST   = 16'h2000;
    localparam logic [15:0] LIN_LAST    = 16'h29ff;
    localparam logic [15:0] PROG_FIRST  = 16'h8000;

    // ****************************************************************
    // Core register addresses inside every bank
    // ****************************************************************
    localparam logic [6:0] FA_PORT0    = 7'h00;
    localparam logic [6:0] FA_PORT1    = 7'h01;
    localparam logic [6:0] FA_PTR_BASE = 7'h04;
    localparam logic [6:0] FA_PTR_LAST = 7'h07;

    // ****************************************************************
    // Linear view layout and reset values
    // ****************************************************************
    localparam logic [6:0]  GPR_BASE   = 7'h20;
    localparam logic [11:0] GPR_BLOCK  = 12'h050;
    localparam logic [15:0] DIV5_MUL   = 16'h00cd;
    localparam int          DIV5_SHIFT = 10;
    localparam logic [15:0] PTR_RESET  = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_BRANCH_W = 3'h1,
        OP_PTR_ADD  = 3'h2,
        OP_LOAD     = 3'h3,
        OP_STORE    = 3'h4,
        OP_FILE_RD  = 3'h5,
        OP_FILE_WR  = 3'h6
    } iau_op_t;

    typedef enum logic [2:0] {
        MD_PRE_INC  = 3'h0,
        MD_PRE_DEC  = 3'h1,
        MD_POST_INC = 3'h2,
        MD_POST_DEC = 3'h3,
        MD_OFFSET   = 3'h4
    } iau_mode_t;

    typedef enum logic [1:0] {
        TG_RAM  = 2'h0,
        TG_PROG = 2'h1,
        TG_ZERO = 2'h2,
        TG_PTR  = 2'h3
    } iau_tgt_t;

    typedef struct packed {
        logic                 valid;
        iau_op_t              op;
        logic                 sel;
        iau_mode_t            mode;
        logic [LIT_W-1:0]     lit;
        logic [FA_W-1:0]      file_addr;
        logic [DW-1:0]        wval;
        logic [PROG_AW-1:0]   pc;
    } iau_req_t;

    typedef struct packed {
        logic                 done;
        logic                 w_write;
        logic [DW-1:0]        rdata;
        logic                 branch_valid;
        logic [PROG_AW-1:0]   branch_pc;
    } iau_rsp_t;

endpackage

// [hdl/iau_addr_map.sv]
// Decoder from a 16-bit pointer address to its backing store
`timescale 1ns/1ps
`default_nettype none

module iau_addr_map (
    input  wire logic [15:0]              addr,
    output iau_pkg::iau_tgt_t             tgt,
    output logic [iau_pkg::RAM_AW-1:0]    ram_addr,
    output logic [iau_pkg::PROG_AW-1:0]   prog_addr,
    output logic [1:0]                    ptr_byte
);
    import iau_pkg::*;

    logic [11:0] lin_off;
    logic [15:0] quot_prod;
    logic [4:0]  lin_bank;
    logic [11:0] blk_start;
    logic [6:0]  blk_off;

    // ****************************************************************
    // Linear view: 80-byte blocks back to back
    // ****************************************************************
    // Divide by 80 as (n/16)/5; multiply by 205 >> 10 is exact below 160
    always_comb begin
        lin_off   = addr[11:0];
        quot_prod = {8'h00, lin_off[11:4]} * DIV5_MUL;
        lin_bank  = quot_prod[DIV5_SHIFT +: BANK_W];
        blk_start = 12'({7'h00, lin_bank} * GPR_BLOCK);
        blk_off   = 7'(lin_off - blk_start);
    end

    // ****************************************************************
    // Region decode
    // ****************************************************************
    always_comb begin
        tgt       = TG_ZERO;
        ram_addr  = addr[11:0];
        prog_addr = addr[14:0];
        ptr_byte  = addr[1:0];
        if (addr >= PROG_FIRST) begin
            tgt = TG_PROG;
        end else if (addr <= BANKED_LAST) begin
            if (addr[6:0] >= FA_PTR_BASE && addr[6:0] <= FA_PTR_LAST) begin
                tgt = TG_PTR;
            end else if (addr[6:0] == FA_PORT0 || addr[6:0] == FA_PORT1) begin
                tgt = TG_ZERO;
            end else begin
                tgt = TG_RAM;
            end
        end else if (addr >= LIN_FIRST && addr <= LIN_LAST) begin
            tgt      = TG_RAM;
            ram_addr = {lin_bank, 7'(GPR_BASE + blk_off)};
        end else begin
            tgt = TG_ZERO;
        end
    end

endmodule

`default_nettype wire

// [hdl/iau_top.sv]
// Indirect addressing, pointer arithmetic and branch-by-W unit
`timescale 1ns/1ps
`default_nettype none

// Contract
// - branch_by_w jumps forward from PC by unsigned W, reach 0 to 255
// - Two independent 16-bit pointer_reg, each with its own indirect_port
// - Pointer 0x0000-0x0FFF reaches the banked special_regs and general_ram
// - Pointer 0x1000-0x1FFF is reserved and reads zero
// - Pointer 0x2000-0x29FF is a linear general_ram view, pointer only
// - Linear view stacks each bank's 80-byte general_ram block back to back
// - Pointer 0x8000-0xFFFF maps to program words 0x0000-0x7FFF
// - Program region reads return the low 8 bits of the word
// - Program region access takes one extra fetch cycle, three in all
// - pointer_add_literal adds signed -32 to 31 into the selected pointer
// - indirect_load_to_w copies the byte at the effective address to W
// - indirect_store_from_w writes W to the effective address
// - Pre-increment bumps the pointer, then accesses the new address
// - Post-increment accesses the current address, then bumps the pointer
// - Pre-decrement lowers the pointer, then accesses the new address
// - Post-decrement accesses the current address, then lowers the pointer
// - Relative mode accesses pointer plus signed -32 to +31
// - Relative mode leaves the pointer unchanged
// - branch_by_w takes two cycles
// - indirect_port access into program memory costs one more cycle
// - Pointer bytes sit at core addresses, pointer zero low at 0x04
module iau_top #(
    parameter int PROG_WORD_W = 14
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire iau_pkg::iau_req_t             req,
    input  wire logic [iau_pkg::BANK_W-1:0]    bank_select,
    input  wire logic [iau_pkg::DW-1:0]        ram_rdata,
    input  wire logic [PROG_WORD_W-1:0]        prog_rdata,
    output iau_pkg::iau_rsp_t                  rsp,
    output logic                               busy,
    output logic [iau_pkg::PTR_W-1:0]          pointer0,
    output logic [iau_pkg::PTR_W-1:0]          pointer1,
    output logic [iau_pkg::RAM_AW-1:0]         ram_addr,
    output logic                               ram_wr_en,
    output logic [iau_pkg::DW-1:0]             ram_wdata,
    output logic [iau_pkg::PROG_AW-1:0]        prog_addr
);
    import iau_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    generate
        if (PROG_WORD_W < DW) begin : g_bad_width
            $error("PROG_WORD_W must be at least 8");
        end
    endgenerate

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_FETCH  = 4'b0010,
        ST_ACCESS = 4'b0100,
        ST_BRANCH = 4'b1000
    } iau_state_t;

    // ****************************************************************
    // State
    // ****************************************************************
    iau_state_t            state;
    iau_state_t            next_state;
    logic [PTR_W-1:0]      ptr      [2];
    logic [PTR_W-1:0]      next_ptr [2];
    iau_rsp_t              next_rsp;
    logic                  next_busy;
    logic [RAM_AW-1:0]     next_ram_addr;
    logic                  next_ram_wr_en;
    logic [DW-1:0]         next_ram_wdata;
    logic [PROG_AW-1:0]    next_prog_addr;
    iau_tgt_t              acc_tgt;
    iau_tgt_t              next_acc_tgt;
    logic [1:0]            acc_byte;
    logic [1:0]            next_acc_byte;
    logic                  acc_write;
    logic                  next_acc_write;
    logic                  acc_to_w;
    logic                  next_acc_to_w;
    logic [DW-1:0]         prog_byte;
    logic [DW-1:0]         next_prog_byte;
    logic [PROG_AW-1:0]    br_pc;
    logic [PROG_AW-1:0]    next_br_pc;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    logic [PTR_W-1:0]      sel_ptr;
    logic [PTR_W-1:0]      lit_ext;
    logic [PTR_W-1:0]      eff_addr;
    logic [PTR_W-1:0]      upd_ptr;
    logic                  is_mem_op;
    logic                  is_write;
    logic                  is_direct;
    iau_tgt_t              map_tgt;
    logic [RAM_AW-1:0]     map_ram_addr;
    logic [PROG_AW-1:0]    map_prog_addr;
    logic [1:0]            map_byte;
    iau_tgt_t              req_tgt;
    logic [RAM_AW-1:0]     req_ram_addr;
    logic [1:0]            req_byte;
    logic [DW-1:0]         acc_rdata;

    function automatic logic is_ptr_file(input logic [FA_W-1:0] fa);
        is_ptr_file = (fa >= FA_PTR_BASE) && (fa <= FA_PTR_LAST);
    endfunction

    function automatic logic is_port_file(input logic [FA_W-1:0] fa);
        is_port_file = (fa == FA_PORT0) || (fa == FA_PORT1);
    endfunction

    always_comb begin
        lit_ext   = {{(PTR_W-LIT_W){req.lit[LIT_W-1]}}, req.lit};
        is_write  = (req.op == OP_STORE) || (req.op == OP_FILE_WR);
        is_mem_op = (req.op == OP_LOAD) || (req.op == OP_STORE) ||
                    (req.op == OP_FILE_RD) || (req.op == OP_FILE_WR);
        is_direct = (req.op == OP_FILE_RD || req.op == OP_FILE_WR) &&
                    !is_port_file(req.file_addr);
        // A file access to an indirect port uses the pointer the port names
        if (req.op == OP_FILE_RD || req.op == OP_FILE_WR) begin
            sel_ptr = ptr[req.file_addr[0]];
        end else begin
            sel_ptr = ptr[req.sel];
        end
        eff_addr = sel_ptr;
        upd_ptr  = sel_ptr;
        if (req.op == OP_PTR_ADD) begin
            upd_ptr = sel_ptr + lit_ext;
        end else if (req.op == OP_LOAD || req.op == OP_STORE) begin
            case (req.mode)
                MD_PRE_INC: begin
                    upd_ptr  = sel_ptr + 16'h0001;
                    eff_addr = upd_ptr;
                end
                MD_PRE_DEC: begin
                    upd_ptr  = sel_ptr - 16'h0001;
                    eff_addr = upd_ptr;
                end
                MD_POST_INC: begin
                    upd_ptr = sel_ptr + 16'h0001;
                end
                MD_POST_DEC: begin
                    upd_ptr = sel_ptr - 16'h0001;
                end
                MD_OFFSET: begin
                    eff_addr = sel_ptr + lit_ext;
                end
                default: begin
                    upd_ptr = sel_ptr;
                end
            endcase
        end
    end

    iau_addr_map u_map (
        .addr      (eff_addr),
        .tgt       (map_tgt),
        .ram_addr  (map_ram_addr),
        .prog_addr (map_prog_addr),
        .ptr_byte  (map_byte)
    );

    // Direct file accesses bypass the pointer map and use the bank
    always_comb begin
        req_tgt      = map_tgt;
        req_ram_addr = map_ram_addr;
        req_byte     = map_byte;
        if (is_direct) begin
            req_byte     = req.file_addr[1:0];
            req_ram_addr = {bank_select, req.file_addr};
            req_tgt      = is_ptr_file(req.file_addr) ? TG_PTR : TG_RAM;
        end
    end

    // ****************************************************************
    // Read data selection in the access cycle
    // ****************************************************************
    always_comb begin
        case (acc_tgt)
            TG_RAM:  acc_rdata = ram_rdata;
            TG_PROG: acc_rdata = prog_byte;
            TG_PTR:  acc_rdata = ptr[acc_byte[1]][acc_byte[0]*8 +: 8];
            default: acc_rdata = ZERO_BYTE;
        endcase
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_state     = state;
        next_ptr       = ptr;
        next_rsp       = '0;
        next_rsp.rdata = rsp.rdata;
        next_ram_addr  = ram_addr;
        next_ram_wr_en = 1'b0;
        next_ram_wdata = ram_wdata;
        next_prog_addr = prog_addr;
        next_acc_tgt   = acc_tgt;
        next_acc_byte  = acc_byte;
        next_acc_write = acc_write;
        next_acc_to_w  = acc_to_w;
        next_prog_byte = prog_byte;
        next_br_pc     = br_pc;
        case (state)
            ST_IDLE: begin
                if (req.valid && req.op == OP_BRANCH_W) begin
                    // Zero-extended W, so the jump never goes backwards
                    next_br_pc = req.pc + {7'h00, req.wval};
                    next_state = ST_BRANCH;
                end else if (req.valid && req.op == OP_PTR_ADD) begin
                    next_ptr[req.sel] = upd_ptr;
                    next_rsp.done     = 1'b1;
                end else if (req.valid && is_mem_op) begin
                    // Load and store write upd_ptr back; relative mode leaves it equal to the pointer
                    if (!is_direct && req.op != OP_FILE_RD && req.op != OP_FILE_WR) begin
                        next_ptr[req.sel] = upd_ptr;
                    end
                    next_acc_tgt   = req_tgt;
                    next_acc_byte  = req_byte;
                    next_acc_write = is_write;
                    next_acc_to_w  = (req.op == OP_LOAD);
                    next_ram_addr  = req_ram_addr;
                    next_ram_wdata = req.wval;
                    next_prog_addr = map_prog_addr;
                    if (req_tgt == TG_PROG) begin
                        next_state = ST_FETCH;
                    end else begin
                        next_ram_wr_en = is_write && (req_tgt == TG_RAM);
                        next_state     = ST_ACCESS;
                    end
                end
            end
            ST_FETCH: begin
                next_prog_byte = prog_rdata[DW-1:0];
                next_state     = ST_ACCESS;
            end
            ST_ACCESS: begin
                next_rsp.done = 1'b1;
                if (acc_write) begin
                    // Program and reserved targets drop the write
                    if (acc_tgt == TG_PTR) begin
                        next_ptr[acc_byte[1]][acc_byte[0]*8 +: 8] = ram_wdata;
                    end
                end else begin
                    next_rsp.rdata   = acc_rdata;
                    next_rsp.w_write = acc_to_w;
                end
                next_state = ST_IDLE;
            end
            ST_BRANCH: begin
                next_rsp.done         = 1'b1;
                next_rsp.branch_valid = 1'b1;
                next_rsp.branch_pc    = br_pc;
                next_state            = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_busy = (next_state != ST_IDLE);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            ptr[0]    <= PTR_RESET;
            ptr[1]    <= PTR_RESET;
            rsp       <= '0;
            busy      <= 1'b0;
            ram_addr  <= '0;
            ram_wr_en <= 1'b0;
            ram_wdata <= '0;
            prog_addr <= '0;
            acc_tgt   <= TG_ZERO;
            acc_byte  <= '0;
            acc_write <= 1'b0;
            acc_to_w  <= 1'b0;
            prog_byte <= '0;
            br_pc     <= '0;
        end else begin
            state     <= next_state;
            ptr       <= next_ptr;
            rsp       <= next_rsp;
            busy      <= next_busy;
            ram_addr  <= next_ram_addr;
            ram_wr_en <= next_ram_wr_en;
            ram_wdata <= next_ram_wdata;
            prog_addr <= next_prog_addr;
            acc_tgt   <= next_acc_tgt;
            acc_byte  <= next_acc_byte;
            acc_write <= next_acc_write;
            acc_to_w  <= next_acc_to_w;
            prog_byte <= next_prog_byte;
            br_pc     <= next_br_pc;
        end
    end

    // Pointer copies for the outside are registered alongside ptr
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pointer0 <= PTR_RESET;
            pointer1 <= PTR_RESET;
        end else begin
            pointer0 <= next_ptr[0];
            pointer1 <= next_ptr[1];
        end
    end

endmodule

`default_nettype wire

// [test/iau_checker.sv]
// Port-level assertions for the indirect address unit
`timescale 1ns/1ps
`default_nettype none

module iau_checker (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire iau_pkg::iau_req_t   req,
    input  wire iau_pkg::iau_rsp_t   rsp,
    input  wire logic                busy,
    input  wire logic [15:0]         pointer0,
    input  wire logic [15:0]         pointer1,
    input  wire logic                ram_wr_en,
    input  wire logic [14:0]         prog_addr
);
    import iau_pkg::*;

    logic        take;
    logic [15:0] lit16;

    assign take   = req.valid && !busy && req.op != OP_NONE;
    assign lit16  = {{10{req.lit[5]}}, req.lit};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence s_add;
        take && req.op == OP_PTR_ADD;
    endsequence
    sequence s_branch;
        take && req.op == OP_BRANCH_W;
    endsequence
    sequence s_prog_rd;
        take && req.op == OP_FILE_RD && req.file_addr == FA_PORT0 && pointer0[15];
    endsequence
    // Fetch cycle: address out first, data lands one edge later
    sequence s_fetch_wait;
        busy && prog_addr == $past(pointer0[14:0]) ##1 busy && !rsp.done;
    endsequence

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_add;
        s_add |=> rsp.done && ($past(req.sel) ? pointer1 - $past(pointer1)
                                              : pointer0 - $past(pointer0)) == $past(lit16);
    endproperty
    property p_branch;
        s_branch |=> busy && !rsp.done ##1 (rsp.done && rsp.branch_valid && !busy &&
            rsp.branch_pc == $past(req.pc, 2) + 15'($past(req.wval, 2)));
    endproperty
    property p_prog_rd;
        s_prog_rd |=> s_fetch_wait ##1 rsp.done;
    endproperty
    property p_ld_time;
        take && req.op == OP_LOAD && req.mode == MD_POST_INC && !req.sel && !pointer0[15]
            |=> busy && !rsp.done ##1 rsp.done && rsp.w_write && !busy;
    endproperty
    property p_post_inc;
        take && req.op == OP_LOAD && req.mode == MD_POST_INC && !req.sel
            |=> pointer0 == $past(pointer0) + 16'h0001;
    endproperty
    property p_pre_dec;
        take && req.op == OP_LOAD && req.mode == MD_PRE_DEC && req.sel
            |=> pointer1 == $past(pointer1) - 16'h0001;
    endproperty
    property p_offset;
        take && req.op == OP_LOAD && req.mode == MD_OFFSET
            |=> ($stable(pointer0) && $stable(pointer1))[*2];
    endproperty
    property p_prog_nowr;
        take && req.op == OP_STORE && req.sel && req.mode == MD_POST_INC && pointer1[15]
            |=> !ram_wr_en[*3];
    endproperty

    a_add: assert property (p_add) else $error("pointer add wrong");
    a_branch: assert property (p_branch) else $error("branch wrong");
    a_prog_rd: assert property (p_prog_rd) else $error("program read timing");
    a_ld_time: assert property (p_ld_time) else $error("load timing");
    a_post_inc: assert property (p_post_inc) else $error("post increment");
    a_pre_dec: assert property (p_pre_dec) else $error("pre decrement");
    a_offset: assert property (p_offset) else $error("offset moved pointer");
    a_prog_nowr: assert property (p_prog_nowr) else $error("program write");
endmodule

`default_nettype wire

// [test/iau_mem_model.sv]
// Data RAM and program memory behind the indirect address unit
`timescale 1ns/1ps
`default_nettype none

module iau_mem_model #(
    parameter int PROG_WORD_W = 14
) (
    input  wire logic                    clk,
    input  wire logic [11:0]             ram_addr,
    input  wire logic                    ram_wr_en,
    input  wire logic [7:0]              ram_wdata,
    output logic [7:0]                   ram_rdata,
    input  wire logic [14:0]             prog_addr,
    output logic [PROG_WORD_W-1:0]       prog_rdata
);
    logic [7:0] ram [0:4095];

    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'(i) ^ {4'(i >> 8), 4'h9};
        end
    end

    always @(posedge clk) begin
        if (ram_wr_en) begin
            ram[ram_addr] <= ram_wdata;
        end
    end

    assign ram_rdata  = ram[ram_addr];
    // Upper bits set so a missing low-byte mask shows up
    assign prog_rdata = PROG_WORD_W'({~prog_addr[5:0], prog_addr[7:0] ^ 8'h5a});
endmodule

`default_nettype wire

// [test/tb_iau_top.sv]
// Self-checking testbench of the indirect address unit
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb_iau_top;
    import iau_pkg::*;

    logic             clk;
    logic             rst;
    iau_req_t         req;
    iau_rsp_t         rsp;
    logic [4:0]       bank_select;
    logic [7:0]       ram_rdata;
    logic [13:0]      prog_rdata;
    logic             busy;
    logic [15:0]      pointer0;
    logic [15:0]      pointer1;
    logic [11:0]      ram_addr;
    logic             ram_wr_en;
    logic [7:0]       ram_wdata;
    logic [14:0]      prog_addr;
    int               fails;
    int               checked;
    int               cyc;
    int               cycles;

    iau_top dut (.clk(clk), .rst(rst), .req(req), .bank_select(bank_select),
        .ram_rdata(ram_rdata), .prog_rdata(prog_rdata), .rsp(rsp), .busy(busy),
        .pointer0(pointer0), .pointer1(pointer1), .ram_addr(ram_addr),
        .ram_wr_en(ram_wr_en), .ram_wdata(ram_wdata), .prog_addr(prog_addr));
    iau_mem_model mem (.clk(clk), .ram_addr(ram_addr), .ram_wr_en(ram_wr_en),
        .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata));

    always #5 clk = ~clk;

    function automatic logic [7:0] ram_pat(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h9};
    endfunction

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Done is a one-cycle pulse, so poll every edge after the take edge
    task automatic run(input iau_op_t op, input logic s, input iau_mode_t m,
                       input logic [5:0] l, input logic [6:0] fa, input logic [7:0] wv);
        @(posedge clk);
        req <= '{1'b1, op, s, m, l, fa, wv, 15'h0100};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        cyc = 0;
        while (rsp.done !== 1'b1 && cyc < 8) begin
            @(posedge clk);
            #1;
            cyc++;
        end
    endtask

    task automatic set_ptr(input logic s, input logic [15:0] v);
        run(OP_FILE_WR, 1'b0, MD_PRE_INC, 6'h00, 7'(4 + 2 * s), v[7:0]);
        run(OP_FILE_WR, 1'b0, MD_PRE_INC, 6'h00, 7'(5 + 2 * s), v[15:8]);
        `CHK("ptr_set", v, (s ? pointer1 : pointer0))
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_linear();
        set_ptr(1'b0, 16'h2050);
        run(OP_LOAD, 1'b0, MD_POST_INC, 6'h00, 7'h00, 8'h00);
        `CHK("ld_cyc", 1, cyc)
        `CHK("ld_w", 1'b1, rsp.w_write)
        `CHK("lin_data", ram_pat(12'h0a0), rsp.rdata)
        `CHK("post_inc", 16'h2051, pointer0)
        set_ptr(1'b0, 16'h20f4);
        run(OP_LOAD, 1'b0, MD_PRE_INC, 6'h00, 7'h00, 8'h00);
        `CHK("pre_inc_data", ram_pat(12'h1a5), rsp.rdata)
        `CHK("pre_inc", 16'h20f5, pointer0)
    endtask

    task automatic t_banked();
        set_ptr(1'b1, 16'h0121);
        run(OP_LOAD, 1'b1, MD_PRE_DEC, 6'h00, 7'h00, 8'h00);
        `CHK("bank_data", ram_pat(12'h120), rsp.rdata)
        `CHK("pre_dec", 16'h0120, pointer1)
        set_ptr(1'b1, 16'h1000);
        run(OP_LOAD, 1'b1, MD_POST_DEC, 6'h00, 7'h00, 8'h00);
        `CHK("rsv_data", 8'h00, rsp.rdata)
        `CHK("post_dec", 16'h0fff, pointer1)
        run(OP_FILE_RD, 1'b0, MD_PRE_INC, 6'h00, 7'h07, 8'h00);
        `CHK("ptr_byte_rd", 8'h0f, rsp.rdata)
        @(posedge clk);
        bank_select <= 5'h03;
        run(OP_FILE_RD, 1'b0, MD_PRE_INC, 6'h00, 7'h25, 8'h00);
        `CHK("direct_data", ram_pat(12'h1a5), rsp.rdata)
    endtask

    task automatic t_prog();
        set_ptr(1'b0, 16'h8005);
        run(OP_LOAD, 1'b0, MD_OFFSET, 6'h3d, 7'h00, 8'h00);
        `CHK("prog_cyc", 2, cyc)
        `CHK("prog_data", 8'h58, rsp.rdata)
        `CHK("off_keep", 16'h8005, pointer0)
        run(OP_FILE_RD, 1'b0, MD_PRE_INC, 6'h00, 7'h00, 8'h00);
        `CHK("port_cyc", 2, cyc)
        `CHK("port_data", 8'h5f, rsp.rdata)
        set_ptr(1'b1, 16'h2000);
        run(OP_LOAD, 1'b1, MD_OFFSET, 6'h1f, 7'h00, 8'h00);
        `CHK("off_data", ram_pat(12'h03f), rsp.rdata)
    endtask

    task automatic t_store();
        set_ptr(1'b0, 16'h2010);
        run(OP_STORE, 1'b0, MD_POST_INC, 6'h00, 7'h00, 8'hc3);
        run(OP_LOAD, 1'b0, MD_PRE_DEC, 6'h00, 7'h00, 8'h00);
        `CHK("st_data", 8'hc3, rsp.rdata)
        set_ptr(1'b1, 16'h2a10);
        run(OP_STORE, 1'b1, MD_POST_INC, 6'h00, 7'h00, 8'hc3);
        run(OP_LOAD, 1'b1, MD_PRE_DEC, 6'h00, 7'h00, 8'h00);
        `CHK("rsv_rd", 8'h00, rsp.rdata)
        set_ptr(1'b1, 16'h8010);
        run(OP_STORE, 1'b1, MD_POST_INC, 6'h00, 7'h00, 8'hc3);
        run(OP_LOAD, 1'b1, MD_PRE_DEC, 6'h00, 7'h00, 8'h00);
        `CHK("prog_keep", 8'h4a, rsp.rdata)
    endtask

    task automatic t_add();
        set_ptr(1'b0, 16'hfffe);
        run(OP_PTR_ADD, 1'b0, MD_PRE_INC, 6'h1f, 7'h00, 8'h00);
        `CHK("add_cyc", 0, cyc)
        `CHK("add_wrap", 16'h001d, pointer0)
        set_ptr(1'b1, 16'h0010);
        run(OP_PTR_ADD, 1'b1, MD_PRE_INC, 6'h20, 7'h00, 8'h00);
        `CHK("add_neg", 16'hfff0, pointer1)
        `CHK("ptr_indep", 16'h001d, pointer0)
    endtask

    task automatic t_branch();
        logic [7:0] w [2] = '{8'h00, 8'hff};
        foreach (w[i]) begin
            run(OP_BRANCH_W, 1'b0, MD_PRE_INC, 6'h00, 7'h00, w[i]);
            `CHK("br_cyc", 1, cyc)
            `CHK("br_valid", 1'b1, rsp.branch_valid)
            `CHK("br_pc", 15'h0100 + 15'(w[i]), rsp.branch_pc)
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        bank_select = 5'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_linear();
        t_banked();
        t_prog();
        t_store();
        t_add();
        t_branch();
        results();
    end
endmodule

bind iau_top iau_checker u_chk (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .busy(busy),
    .pointer0(pointer0), .pointer1(pointer1), .ram_wr_en(ram_wr_en), .prog_addr(prog_addr));

`default_nettype wire
